// [odacb_cfg.svh]
// Purpose: shared constants for the eight-channel dac board bus logic
// Assumes: included by bare name from both ends
// Notes:   offsets, field positions, reset values and codes
//
// Functional notes
// - dac word: two power-down bits, 12-bit code
// - load strobe after sixteenth shifted bit
// - answer only address 0010 000z yxMM
// - open jumper reads one, shorted reads zero
// - logical number is z,y,x; default seven
// - low two address bits pick operation
// - select-mode read returns 1010 presence code
// - host sends data bit in bit 0
// - host writes clock low, high, low per bit
// - host writes zero before and after eeprom
// - host resets bus, addresses, then transfers
// - op 00 data, 01 eeprom, 10 select
// - 0111 ref on, 0110 off, 1xxx channel
// - eeprom: wr bit0 data, bit1 clock, rd bit0
// - reset puts every dac in power-down 3
`ifndef ODACB_CFG_SVH
`define ODACB_CFG_SVH

// ----------------------------------------
// bus address and codes
// ----------------------------------------
`define ODACB_ADR_LOW_VAL  4'h2
`define ODACB_ADR_MID_TOP  3'h0
`define ODACB_PRESENCE     4'ha
`define ODACB_REF_ON_CODE  4'h7
`define ODACB_REF_OFF_CODE 4'h6
`define ODACB_CHAN_BIT     3

// ----------------------------------------
// dac word layout
// ----------------------------------------
`define ODACB_WORD_BITS    16
`define ODACB_PD_LSB       12
`define ODACB_WORD_RESET   16'h3000

// ----------------------------------------
// host apb map and fields
// ----------------------------------------
`define ODACB_CMD_OFS      12'h000
`define ODACB_DATA_OFS     12'h004
`define ODACB_STATUS_OFS   12'h008
`define ODACB_CMD_NIB_LSB  0
`define ODACB_CMD_CODE_LSB 4
`define ODACB_CMD_OP_LSB   8
`define ODACB_CMD_BRD_LSB  10
`define ODACB_ST_BUSY      0
`define ODACB_ST_PRESENT   1
`define ODACB_ST_RST_DONE  2
`define ODACB_ST_NIB_LSB   4

`endif

// [odacb_pkg.sv]
// Purpose: types shared by both ends of the dac board bus
// Assumes: nothing
// Notes:   numbers live in odacb_cfg.svh
package odacb_pkg;

  typedef enum logic [1:0] {
    OP_DATA   = 2'b00,
    OP_EEPROM = 2'b01,
    OP_SELECT = 2'b10,
    OP_NONE   = 2'b11
  } odacb_op_type;

  typedef enum logic [2:0] {
    CMD_RESET  = 3'b000,
    CMD_SELECT = 3'b001,
    CMD_WRITE  = 3'b010,
    CMD_READ   = 3'b011,
    CMD_WORD   = 3'b100,
    CMD_EEIDLE = 3'b101
  } odacb_cmd_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_RST   = 4'b0001,
    ST_ADR0  = 4'b0010,
    ST_ADR1  = 4'b0011,
    ST_ADR2  = 4'b0100,
    ST_WR    = 4'b0101,
    ST_SHIFT = 4'b0110,
    ST_RD    = 4'b0111,
    ST_CAPT  = 4'b1000
  } odacb_state_type;

endpackage : odacb_pkg

// [odacb_bus_if.sv]
// Purpose: expansion bus between host controller and dac board
// Assumes: one clock, all signals driven from flops
// Notes:   rdata only meaningful with rvalid
`timescale 1ns/1ns
interface odacb_bus_if;
  logic       bus_reset;
  logic       bus_address_low_write;
  logic       bus_address_mid_write;
  logic       bus_address_high_write;
  logic       bus_nibble_write;
  logic       bus_nibble_read;
  logic [3:0] bus_wdata;
  logic [3:0] bus_rdata;
  logic       bus_rvalid;

  modport host_end (
    output bus_reset, bus_address_low_write, bus_address_mid_write,
    output bus_address_high_write, bus_nibble_write, bus_nibble_read,
    output bus_wdata,
    input  bus_rdata, bus_rvalid
  );

  modport board_end (
    input  bus_reset, bus_address_low_write, bus_address_mid_write,
    input  bus_address_high_write, bus_nibble_write, bus_nibble_read,
    input  bus_wdata,
    output bus_rdata, bus_rvalid
  );
endinterface : odacb_bus_if

// [odacb_board_end.sv]
// Purpose: board logic of the eight-channel dac card
// Assumes: host keeps the bus order and bit sequencing
// Notes:   dac words are kept on board as the chips' latches
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "odacb_cfg.svh"
module odacb_board_end
  import odacb_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  odacb_bus_if.board_end                bus,
  input  wire logic [2:0]               board_address_jumpers,
  input  wire logic                     ee_sda_in,
  output logic                          ee_sda_out,
  output logic                          ee_sda_oe,
  output logic                          ee_scl,
  output logic                          dac_sdata,
  output logic                          dac_sclk,
  output logic [CHANNELS-1:0]           dac_sync_n,
  output logic [CHANNELS-1:0]           dac_load,
  output logic [`ODACB_WORD_BITS*CHANNELS-1:0] dac_words,
  output logic                          ref_on,
  output logic                          board_selected,
  output logic [2:0]                    board_number
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] jmp_s1_reg, jmp_s2_reg, jmp_s3_reg, jumper_reg;
  logic       sda_s1_reg, sda_s2_reg, sda_s3_reg, sda_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      jmp_s1_reg <= 3'h7;
      jmp_s2_reg <= 3'h7;
      jmp_s3_reg <= 3'h7;
    end else begin
      jmp_s1_reg <= board_address_jumpers;
      jmp_s2_reg <= jmp_s1_reg;
      jmp_s3_reg <= jmp_s2_reg;
    end
  end

  // open pair pulls high, so the level is the bit itself
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      jumper_reg <= 3'h7;
    end else if (jmp_s2_reg == jmp_s3_reg) begin
      jumper_reg <= jmp_s3_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      sda_reg    <= 1'b1;
    end else begin
      sda_s1_reg <= ee_sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      if (sda_s2_reg == sda_s3_reg) begin
        sda_reg <= sda_s3_reg;
      end
    end
  end

  // ----------------------------------------
  // address capture and decode
  // ----------------------------------------
  logic [3:0]   adr_low_reg, adr_mid_reg, adr_high_reg;
  logic         match;
  odacb_op_type op;

  always_ff @(posedge sys_clk) begin
    if (!rstn || bus.bus_reset) begin
      adr_low_reg  <= 4'h0;
      adr_mid_reg  <= 4'h0;
      adr_high_reg <= 4'h0;
    end else begin
      if (bus.bus_address_low_write) adr_low_reg <= bus.bus_wdata;
      if (bus.bus_address_mid_write) adr_mid_reg <= bus.bus_wdata;
      if (bus.bus_address_high_write) adr_high_reg <= bus.bus_wdata;
    end
  end

  // jumper order is z, y, x from msb down
  always_comb begin
    match = (adr_low_reg == `ODACB_ADR_LOW_VAL) &&
            (adr_mid_reg == {`ODACB_ADR_MID_TOP, jumper_reg[2]}) &&
            (adr_high_reg[3:2] == jumper_reg[1:0]);
    op = odacb_op_type'(adr_high_reg[1:0]);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      board_selected <= 1'b0;
      board_number   <= 3'h7;
    end else begin
      board_selected <= match;
      board_number   <= jumper_reg;
    end
  end

  logic wr_hit, rd_hit, adr_any;
  assign wr_hit  = bus.bus_nibble_write && match;
  assign rd_hit  = bus.bus_nibble_read && match;
  assign adr_any = bus.bus_address_low_write || bus.bus_address_mid_write ||
                   bus.bus_address_high_write;

  // ----------------------------------------
  // select mode: reference and channel
  // ----------------------------------------
  logic [2:0] chan_reg;
  logic       chan_valid_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ref_on         <= 1'b0;
      chan_reg       <= 3'h0;
      chan_valid_reg <= 1'b0;
    end else if (bus.bus_reset) begin
      chan_valid_reg <= 1'b0;
    end else if (wr_hit && op == OP_SELECT) begin
      if (bus.bus_wdata == `ODACB_REF_ON_CODE) ref_on <= 1'b1;
      if (bus.bus_wdata == `ODACB_REF_OFF_CODE) ref_on <= 1'b0;
      if (bus.bus_wdata[`ODACB_CHAN_BIT]) begin
        chan_reg       <= bus.bus_wdata[2:0];
        chan_valid_reg <= 32'(bus.bus_wdata[2:0]) < CHANNELS;
      end
    end
  end

  // ----------------------------------------
  // data mode: serial shift and load
  // ----------------------------------------
  logic [`ODACB_WORD_BITS-1:0] shift_reg, shift_next;
  logic [3:0]                  count_reg;
  logic                        rise;

  assign rise       = wr_hit && op == OP_DATA && chan_valid_reg &&
                      bus.bus_wdata[1] && !dac_sclk;
  assign shift_next = {shift_reg[`ODACB_WORD_BITS-2:0], bus.bus_wdata[0]};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dac_sdata <= 1'b0;
      dac_sclk  <= 1'b0;
    end else if (wr_hit && op == OP_DATA) begin
      dac_sdata <= bus.bus_wdata[0];
      dac_sclk  <= bus.bus_wdata[1];
    end
  end

  // a new address or channel abandons a partial word
  always_ff @(posedge sys_clk) begin
    if (!rstn || bus.bus_reset || adr_any) begin
      shift_reg <= '0;
      count_reg <= 4'h0;
    end else if (wr_hit && op == OP_SELECT && bus.bus_wdata[`ODACB_CHAN_BIT]) begin
      count_reg <= 4'h0;
    end else if (rise) begin
      shift_reg <= shift_next;
      count_reg <= count_reg + 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          dac_words[gi*`ODACB_WORD_BITS +: `ODACB_WORD_BITS] <= `ODACB_WORD_RESET;
          dac_load[gi]   <= 1'b0;
          dac_sync_n[gi] <= 1'b1;
        end else begin
          dac_sync_n[gi] <= !(match && op == OP_DATA && chan_valid_reg &&
                              32'(chan_reg) == gi);
          dac_load[gi]   <= 1'b0;
          if (rise && count_reg == 4'hf && 32'(chan_reg) == gi) begin
            dac_words[gi*`ODACB_WORD_BITS +: `ODACB_WORD_BITS] <= shift_next;
            dac_load[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // eeprom lines
  // ----------------------------------------
  // data line is open drain: only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ee_sda_out <= 1'b0;
      ee_sda_oe  <= 1'b0;
      ee_scl     <= 1'b0;
    end else if (wr_hit && op == OP_EEPROM) begin
      ee_sda_out <= 1'b0;
      ee_sda_oe  <= !bus.bus_wdata[0];
      ee_scl     <= bus.bus_wdata[1];
    end
  end

  // ----------------------------------------
  // read answers
  // ----------------------------------------
  logic [3:0] rdata_reg;
  logic       rvalid_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_reg  <= 4'h0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_hit;
      rdata_reg  <= 4'h0;
      if (rd_hit) begin
        case (op)
          OP_SELECT: rdata_reg <= `ODACB_PRESENCE;
          OP_EEPROM: rdata_reg <= {3'h0, sda_reg};
          default:   rdata_reg <= 4'h0;
        endcase
      end
    end
  end

  assign bus.bus_rdata  = rdata_reg;
  assign bus.bus_rvalid = rvalid_reg;

endmodule : odacb_board_end

// [odacb_host_end.sv]
// Purpose: host controller end, apb commands to bus cycles
// Assumes: board answers a read on the next clock
// Notes:   one command at a time; busy commands are dropped
`timescale 1ns/1ns
`include "odacb_cfg.svh"
module odacb_host_end
  import odacb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  odacb_bus_if.host_end    bus
);

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  odacb_state_type state_reg;
  logic [15:0]     word_reg;
  logic [3:0]      nib_reg, rd_nib_reg;
  logic [1:0]      op_reg;
  logic [2:0]      brd_reg;
  logic            present_reg, reset_done_reg;
  logic            acc, cmd_go;
  logic [31:0]     status;
  // remembers whether the pending reset came from a select
  logic            cmd_go_was_select;

  assign acc    = psel && penable && pready;
  assign cmd_go = acc && pwrite && paddr == `ODACB_CMD_OFS && state_reg == ST_IDLE;
  assign status = {24'h0, rd_nib_reg, 1'b0, reset_done_reg, present_reg,
                   state_reg != ST_IDLE};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        case (paddr)
          `ODACB_DATA_OFS:   prdata <= {16'h0000, word_reg};
          `ODACB_STATUS_OFS: prdata <= status;
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      word_reg <= 16'h0000;
    end else if (acc && pwrite && paddr == `ODACB_DATA_OFS) begin
      word_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  logic [3:0] bit_reg;
  logic [1:0] phase_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg      <= ST_IDLE;
      nib_reg        <= 4'h0;
      op_reg         <= 2'h0;
      brd_reg        <= 3'h0;
      bit_reg        <= 4'h0;
      phase_reg      <= 2'h0;
      reset_done_reg <= 1'b0;
      present_reg    <= 1'b0;
      rd_nib_reg     <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_go) begin
            nib_reg   <= pwdata[`ODACB_CMD_NIB_LSB +: 4];
            op_reg    <= pwdata[`ODACB_CMD_OP_LSB +: 2];
            brd_reg   <= pwdata[`ODACB_CMD_BRD_LSB +: 3];
            bit_reg   <= 4'hf;
            phase_reg <= 2'h0;
            case (odacb_cmd_type'(pwdata[`ODACB_CMD_CODE_LSB +: 3]))
              CMD_RESET:  state_reg <= ST_RST;
              CMD_SELECT: state_reg <= reset_done_reg ? ST_ADR0 : ST_RST;
              CMD_WRITE:  state_reg <= ST_WR;
              CMD_READ:   state_reg <= ST_RD;
              CMD_WORD:   state_reg <= ST_SHIFT;
              CMD_EEIDLE: begin
                nib_reg   <= 4'h0;
                state_reg <= ST_WR;
              end
              default:    state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_RST: begin
          reset_done_reg <= 1'b1;
          // a select that forced this reset goes on to address
          state_reg <= (cmd_go_was_select) ? ST_ADR0 : ST_IDLE;
        end
        ST_ADR0:  state_reg <= ST_ADR1;
        ST_ADR1:  state_reg <= ST_ADR2;
        ST_ADR2:  state_reg <= ST_IDLE;
        ST_WR:    state_reg <= ST_IDLE;
        ST_SHIFT: begin
          phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
          if (phase_reg == 2'h2) begin
            bit_reg <= bit_reg - 4'h1;
            if (bit_reg == 4'h0) state_reg <= ST_IDLE;
          end
        end
        ST_RD:    state_reg <= ST_CAPT;
        ST_CAPT: begin
          // strobe reaches the bus a cycle late, the answer one more
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h1) begin
            present_reg <= bus.bus_rvalid;
            rd_nib_reg  <= bus.bus_rvalid ? bus.bus_rdata : 4'h0;
            phase_reg   <= 2'h0;
            state_reg   <= ST_IDLE;
          end
        end
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_go_was_select <= 1'b0;
    end else if (cmd_go) begin
      cmd_go_was_select <= pwdata[`ODACB_CMD_CODE_LSB +: 3] == CMD_SELECT;
    end
  end

  // ----------------------------------------
  // bus strobes, all from flops
  // ----------------------------------------
  logic       rst_o, adr0_o, adr1_o, adr2_o, wr_o, rd_o;
  logic [3:0] wdata_o;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rst_o   <= 1'b0;
      adr0_o  <= 1'b0;
      adr1_o  <= 1'b0;
      adr2_o  <= 1'b0;
      wr_o    <= 1'b0;
      rd_o    <= 1'b0;
      wdata_o <= 4'h0;
    end else begin
      rst_o  <= state_reg == ST_RST;
      adr0_o <= state_reg == ST_ADR0;
      adr1_o <= state_reg == ST_ADR1;
      adr2_o <= state_reg == ST_ADR2;
      wr_o   <= state_reg == ST_WR || state_reg == ST_SHIFT;
      rd_o   <= state_reg == ST_RD;
      case (state_reg)
        ST_ADR0:  wdata_o <= `ODACB_ADR_LOW_VAL;
        ST_ADR1:  wdata_o <= {`ODACB_ADR_MID_TOP, brd_reg[2]};
        ST_ADR2:  wdata_o <= {brd_reg[1:0], op_reg};
        ST_WR:    wdata_o <= nib_reg;
        // clock low, high, low around a steady data bit
        ST_SHIFT: wdata_o <= {2'b00, phase_reg == 2'h1, word_reg[bit_reg]};
        default:  wdata_o <= 4'h0;
      endcase
    end
  end

  assign bus.bus_reset              = rst_o;
  assign bus.bus_address_low_write  = adr0_o;
  assign bus.bus_address_mid_write  = adr1_o;
  assign bus.bus_address_high_write = adr2_o;
  assign bus.bus_nibble_write       = wr_o;
  assign bus.bus_nibble_read        = rd_o;
  assign bus.bus_wdata              = wdata_o;

endmodule : odacb_host_end

// [odacb_checker.sv]
// Purpose: bus-level assertions between host end and board end
// Assumes: all bus signals driven from flops on sys_clk
// Notes:   op tracked from the last high address nibble
`timescale 1ns/1ns
`include "odacb_cfg.svh"
module odacb_checker
  import odacb_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       bus_reset,
  input wire logic       bus_address_low_write,
  input wire logic       bus_address_mid_write,
  input wire logic       bus_address_high_write,
  input wire logic       bus_nibble_write,
  input wire logic       bus_nibble_read,
  input wire logic [3:0] bus_wdata,
  input wire logic [3:0] bus_rdata,
  input wire logic       bus_rvalid
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [1:0] op_reg;
  logic [3:0] last_wr_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) op_reg <= OP_NONE;
    else if (bus_address_high_write) op_reg <= bus_wdata[1:0];
  end

  // cleared on readdress so a select-mode write never poses as a clock edge
  always_ff @(posedge sys_clk) begin
    if (!rstn || bus_address_high_write) last_wr_reg <= 4'h0;
    else if (bus_nibble_write) last_wr_reg <= bus_wdata;
  end

  // a lone bus reset is legal; only addressing without one is not
  logic rst_seen_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) rst_seen_reg <= 1'b0;
    else if (bus_reset) rst_seen_reg <= 1'b1;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_rvalid_follows_read: assert property (bus_rvalid |-> $past(bus_nibble_read))
    else $error("answer without read one cycle before");
  a_rdata_quiet: assert property (!bus_rvalid |-> bus_rdata == 4'h0)
    else $error("read data not zero outside answer");
  a_presence_code: assert property (bus_rvalid && op_reg == OP_SELECT |-> bus_rdata == `ODACB_PRESENCE)
    else $error("select mode read not presence code");
  a_reset_before_addr: assert property (bus_address_low_write |-> rst_seen_reg)
    else $error("address placed before any bus reset");
  a_addr_sequence: assert property (bus_address_low_write |=> bus_address_mid_write ##1 bus_address_high_write)
    else $error("address nibbles out of order");
  a_addr_low_code: assert property (bus_address_low_write |-> bus_wdata == `ODACB_ADR_LOW_VAL)
    else $error("low address nibble wrong");
  a_addr_mid_code: assert property (bus_address_mid_write |-> bus_wdata[3:1] == `ODACB_ADR_MID_TOP)
    else $error("mid address nibble wrong");
  a_one_strobe: assert property ($onehot0({bus_reset, bus_address_low_write, bus_address_mid_write,
                                           bus_address_high_write, bus_nibble_write, bus_nibble_read}))
    else $error("two bus strobes at once");
  a_data_bit_zero: assert property (bus_nibble_write && op_reg == OP_DATA |-> bus_wdata[3:2] == 2'b00)
    else $error("data mode write uses upper bits");
  a_clk_data_apart: assert property (bus_nibble_write && op_reg == OP_DATA && bus_wdata[1] != last_wr_reg[1]
                                     |-> bus_wdata[0] == last_wr_reg[0])
    else $error("data and clock changed together");

  c_presence: cover property (bus_rvalid && op_reg == OP_SELECT);
  c_data_clock: cover property (bus_nibble_write && op_reg == OP_DATA && bus_wdata[1]);
  c_eeprom_write: cover property (bus_nibble_write && op_reg == OP_EEPROM);
endmodule : odacb_checker

// [octal_dac_board_bus_logic_bench.sv]
// Purpose: host end and board end joined, driven over apb
// Assumes: board jumpers and eeprom data pin driven by bench
// Notes:   one task per scenario; expectations kept in bench
`timescale 1ns/1ns
`include "odacb_cfg.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module octal_dac_board_bus_logic_bench;
  import odacb_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic         sys_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready, pslverr;
  logic [2:0]   jumpers = 3'h7;
  logic         ee_dev_low = 1'b0;
  logic         ee_sda_out, ee_sda_oe, ee_scl, dac_sdata, dac_sclk, ref_on, board_selected;
  logic [7:0]   dac_sync_n, dac_load;
  logic [7:0]   load_seen = 8'h00;
  logic         load_clr = 1'b0;
  logic [127:0] dac_words, exp_words;
  logic [2:0]   board_number;
  int           n_mismatch = 0, check_count = 0, cycles = 0;
  // open-drain data line with pull-up
  wire          ee_sda_in = !(ee_sda_oe || ee_dev_low);

  always #5 sys_clk = ~sys_clk;

  odacb_bus_if bus_i();
  odacb_host_end i_odacb_host_end (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_i));
  odacb_board_end #(.CHANNELS(8)) i_odacb_board_end (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_i),
    .board_address_jumpers(jumpers), .ee_sda_in(ee_sda_in), .ee_sda_out(ee_sda_out),
    .ee_sda_oe(ee_sda_oe), .ee_scl(ee_scl), .dac_sdata(dac_sdata), .dac_sclk(dac_sclk),
    .dac_sync_n(dac_sync_n), .dac_load(dac_load), .dac_words(dac_words), .ref_on(ref_on),
    .board_selected(board_selected), .board_number(board_number));
  odacb_checker i_odacb_checker (.sys_clk(sys_clk), .rstn(rstn), .bus_reset(bus_i.bus_reset),
    .bus_address_low_write(bus_i.bus_address_low_write), .bus_address_mid_write(bus_i.bus_address_mid_write),
    .bus_address_high_write(bus_i.bus_address_high_write), .bus_nibble_write(bus_i.bus_nibble_write),
    .bus_nibble_read(bus_i.bus_nibble_read), .bus_wdata(bus_i.bus_wdata), .bus_rdata(bus_i.bus_rdata),
    .bus_rvalid(bus_i.bus_rvalid));

  always @(posedge sys_clk) begin
    if (load_clr) load_seen <= 8'h00;
    else if (rstn) load_seen <= load_seen | dac_load;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // busy commands are dropped, so wait for idle after each one
  task automatic cmd(input odacb_cmd_type c, input odacb_op_type op, input logic [2:0] brd,
                     input logic [3:0] nib);
    logic [31:0] q;
    apb(1'b1, `ODACB_CMD_OFS, {19'h0, brd, op, 1'b0, c, nib}, q);
    q = 32'h0000_0001;
    while (q[0] !== 1'b0) apb(1'b0, `ODACB_STATUS_OFS, 32'h0000_0000, q);
  endtask : cmd

  task automatic rd_status(output logic [31:0] q);
    cmd(CMD_READ, OP_SELECT, 3'h5, 4'h0);
    apb(1'b0, `ODACB_STATUS_OFS, 32'h0000_0000, q);
  endtask : rd_status

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK("words", {8{16'h3000}}, dac_words)
    `CHK("sync_n", 8'hff, dac_sync_n)
    `CHK("ref_on", 1'b0, ref_on)
    `CHK("number", 3'h7, board_number)
    jumpers <= 3'h5;
    repeat (6) @(posedge sys_clk);
    `CHK("number", 3'h5, board_number)
  endtask : t_reset

  task automatic t_presence;
    logic [31:0] q;
    cmd(CMD_SELECT, OP_SELECT, 3'h3, 4'h0);
    `CHK("sel_other", 1'b0, board_selected)
    cmd(CMD_WRITE, OP_SELECT, 3'h3, 4'h7);
    `CHK("ref_other", 1'b0, ref_on)
    cmd(CMD_SELECT, OP_SELECT, 3'h5, 4'h0);
    `CHK("sel_own", 1'b1, board_selected)
    rd_status(q);
    `CHK("present", 5'h15, {q[7:4], q[1]})
    apb(1'b0, 12'h00c, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
  endtask : t_presence

  task automatic t_ref;
    cmd(CMD_WRITE, OP_SELECT, 3'h5, 4'h7);
    `CHK("ref_on", 1'b1, ref_on)
    cmd(CMD_WRITE, OP_SELECT, 3'h5, 4'h6);
    `CHK("ref_off", 1'b0, ref_on)
  endtask : t_ref

  task automatic t_word(input logic [2:0] ch, input logic [15:0] w, input logic do_sel);
    logic [31:0] q;
    if (do_sel) begin
      cmd(CMD_SELECT, OP_SELECT, 3'h5, 4'h0);
      cmd(CMD_WRITE, OP_SELECT, 3'h5, {1'b1, ch});
      exp_words[16*ch +: 16] = w;
    end else begin
      cmd(CMD_RESET, OP_DATA, 3'h5, 4'h0);
    end
    cmd(CMD_SELECT, OP_DATA, 3'h5, 4'h0);
    `CHK("sync_n", do_sel ? ~(8'h01 << ch) : 8'hff, dac_sync_n)
    load_clr <= 1'b1;
    @(posedge sys_clk);
    load_clr <= 1'b0;
    apb(1'b1, `ODACB_DATA_OFS, {16'h0000, w}, q);
    cmd(CMD_WORD, OP_DATA, 3'h5, 4'h0);
    `CHK("words", exp_words, dac_words)
    `CHK("sdata_sclk", {w[0], 1'b0}, {dac_sdata, dac_sclk})
    `CHK("load", do_sel ? (8'h01 << ch) : 8'h00, load_seen)
  endtask : t_word

  task automatic t_eeprom;
    logic [31:0] q;
    cmd(CMD_SELECT, OP_EEPROM, 3'h5, 4'h0);
    cmd(CMD_EEIDLE, OP_EEPROM, 3'h5, 4'h0);
    `CHK("ee_idle", 3'b010, {ee_scl, ee_sda_oe, ee_sda_out})
    cmd(CMD_WRITE, OP_EEPROM, 3'h5, 4'h3);
    `CHK("ee_lines", 3'b100, {ee_scl, ee_sda_oe, ee_sda_out})
    ee_dev_low <= 1'b1;
    cmd(CMD_READ, OP_EEPROM, 3'h5, 4'h0);
    apb(1'b0, `ODACB_STATUS_OFS, 32'h0000_0000, q);
    `CHK("ee_rd0", 1'b0, q[4])
    ee_dev_low <= 1'b0;
    cmd(CMD_READ, OP_EEPROM, 3'h5, 4'h0);
    apb(1'b0, `ODACB_STATUS_OFS, 32'h0000_0000, q);
    `CHK("ee_rd1", 1'b1, q[4])
    cmd(CMD_EEIDLE, OP_EEPROM, 3'h5, 4'h0);
  endtask : t_eeprom

  // ----------------------------------------
  // closing and main sequence
  // ----------------------------------------
  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    exp_words = {8{16'h3000}};
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_presence();
    t_ref();
    t_word(3'h0, 16'h0a5c, 1'b1);
    t_word(3'h7, 16'h1fff, 1'b1);
    t_word(3'h0, 16'h0123, 1'b0);
    t_eeprom();
    end_of_test();
  end
endmodule : octal_dac_board_bus_logic_bench
